// >>> rtl/fcs_checker.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Checker interrupt enable bit, resets to one
// - Receive error raises checker event when enabled
// - Source select: one MAC side, zero PHY
// - Sixteen-bit error tally clears when read
// - Tally read snapshots 32-bit frame counter
// - Count and snapshot length error frames
// - Count and snapshot alignment error frames
// - Count frames with RX_ER during RX_DV
// - Count and snapshot frames above length limit
// - MAC side plus loopback checks looped data
// - Status bit 14 latches until status read
// - Counters advance only while checker enabled
module fcs_checker (
	input wire logic core_clk, // Device clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic [15:0] reg_addr, // Register index
	input wire logic [15:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [15:0] reg_rdata, // Read data, valid the cycle after reg_rd
	input wire logic phy_rx_dv, // PHY receive path: data valid
	input wire logic phy_rx_er, // PHY receive path: symbol error
	input wire logic phy_frame_end, // PHY receive path: frame finished
	input wire logic [15:0] phy_frame_len, // PHY receive path: frame length in bytes
	input wire logic phy_crc_err, // PHY receive path: bad frame check sequence
	input wire logic phy_len_err, // PHY receive path: length field mismatch
	input wire logic phy_align_err, // PHY receive path: alignment error
	input wire logic mac_rx_dv, // MAC side: data valid
	input wire logic mac_rx_er, // MAC side: symbol error
	input wire logic mac_frame_end, // MAC side: frame finished
	input wire logic [15:0] mac_frame_len, // MAC side: frame length in bytes
	input wire logic mac_crc_err, // MAC side: bad frame check sequence
	input wire logic mac_len_err, // MAC side: length field mismatch
	input wire logic mac_align_err, // MAC side: alignment error
	input wire logic remote_loopback_enable, // Remote loopback active at MAC interface
	output logic loopback_check_active, // Checker is looking at looped-back data
	output logic irq // Level interrupt
);

	// Register and next-state copies
	fcs_pkg::fcs_state_t s_q;
	fcs_pkg::fcs_state_t s_d;

	// Selected stream, after the source mux
	logic sel_dv;
	logic sel_er;
	logic sel_end;
	logic [15:0] sel_len;
	logic sel_crc;
	logic sel_len_err;
	logic sel_align;
	// Frame results of the selected stream
	logic frame_evt; // Frame ends while the checker runs
	logic sym_frame; // Frame carried a symbol error
	logic osz_frame; // Frame exceeded the length limit
	logic err_frame; // Any receive error in the frame
	logic chk_event; // Checker interrupt event
	// Decoded register accesses
	logic rd_tally;
	logic rd_status;

	// Source mux; with loopback on, the MAC side carries the looped frames
	always_comb begin
		if (s_q.source_select) begin
			sel_dv = mac_rx_dv;
			sel_er = mac_rx_er;
			sel_end = mac_frame_end;
			sel_len = mac_frame_len;
			sel_crc = mac_crc_err;
			sel_len_err = mac_len_err;
			sel_align = mac_align_err;
		end else begin
			sel_dv = phy_rx_dv;
			sel_er = phy_rx_er;
			sel_end = phy_frame_end;
			sel_len = phy_frame_len;
			sel_crc = phy_crc_err;
			sel_len_err = phy_len_err;
			sel_align = phy_align_err;
		end
	end

	// Frame classification; nothing is analysed while the checker is off
	always_comb begin
		frame_evt = sel_end && s_q.checker_enable;
		// A symbol error on the frame's last beat still belongs to that frame
		sym_frame = s_q.symbol_seen || (sel_dv && sel_er);
		osz_frame = sel_len > s_q.max_frame_length_limit;
		err_frame = sel_crc || sel_len_err || sel_align || sym_frame || osz_frame;
		chk_event = frame_evt && err_frame && s_q.irq_enable;
		rd_tally = reg_rd && (reg_addr == fcs_pkg::ADDR_TALLY);
		rd_status = reg_rd && (reg_addr == fcs_pkg::ADDR_SUBSYS_STATUS);
	end

	// Next state: register writes, counters, snapshots and read data
	always_comb begin
		s_d = s_q;
		// Symbol error memory lives for one frame of the selected stream
		if (sel_end) begin
			s_d.symbol_seen = 1'b0;
		end else if (sel_dv && sel_er && s_q.checker_enable) begin
			s_d.symbol_seen = 1'b1;
		end
		// Software writes; read-only offsets ignore writes
		if (reg_wr) begin
			case (reg_addr)
				fcs_pkg::ADDR_CHECKER_ENABLE: begin
					s_d.checker_enable = reg_wdata[fcs_pkg::BIT_ENABLE];
				end
				fcs_pkg::ADDR_IRQ_ENABLE: begin
					s_d.irq_enable = reg_wdata[fcs_pkg::BIT_ENABLE];
				end
				fcs_pkg::ADDR_SOURCE_SELECT: begin
					s_d.source_select = reg_wdata[fcs_pkg::BIT_ENABLE];
				end
				fcs_pkg::ADDR_MAX_FRAME_LIMIT: begin
					s_d.max_frame_length_limit = reg_wdata;
				end
				fcs_pkg::ADDR_SUBSYS_MASK: begin
					s_d.subsystem_interrupt_mask = reg_wdata;
				end
				default: begin
					// Unmapped or read-only: no effect
				end
			endcase
		end
		// Snapshot uses the values before this cycle's frame, matching the tally read
		if (rd_tally) begin
			s_d.frame_count_snapshot = s_q.frame_count;
			s_d.length_error_snapshot = s_q.length_errors;
			s_d.alignment_error_snapshot = s_q.align_errors;
			s_d.symbol_error_snapshot = s_q.symbol_errors;
			s_d.oversize_frame_snapshot = s_q.oversize_frames;
			s_d.tally = fcs_pkg::RST_ZERO16;
		end
		// Live counters keep running; only the tally is cleared by the read
		if (frame_evt) begin
			s_d.frame_count = s_q.frame_count + fcs_pkg::ONE32;
			if (sel_len_err) begin
				s_d.length_errors = s_q.length_errors + fcs_pkg::ONE16;
			end
			if (sel_align) begin
				s_d.align_errors = s_q.align_errors + fcs_pkg::ONE16;
			end
			if (sym_frame) begin
				s_d.symbol_errors = s_q.symbol_errors + fcs_pkg::ONE16;
			end
			if (osz_frame) begin
				s_d.oversize_frames = s_q.oversize_frames + fcs_pkg::ONE16;
			end
			// An error in the read cycle is kept: it starts the new tally
			if (err_frame) begin
				s_d.tally = (rd_tally ? fcs_pkg::RST_ZERO16 : s_q.tally) + fcs_pkg::ONE16;
			end
		end
		// Status bit: reading clears it, but a new event in that cycle wins
		if (rd_status) begin
			s_d.checker_generator_status_bit = 1'b0;
		end
		if (chk_event) begin
			s_d.checker_generator_status_bit = 1'b1;
		end
		// Read data for next cycle; unmapped offsets read as zero
		s_d.rdata = fcs_pkg::RST_ZERO16;
		if (reg_rd) begin
			case (reg_addr)
				fcs_pkg::ADDR_SUBSYS_STATUS: begin
					s_d.rdata[fcs_pkg::BIT_CHKGEN] = s_q.checker_generator_status_bit;
				end
				fcs_pkg::ADDR_SUBSYS_MASK: begin
					s_d.rdata = s_q.subsystem_interrupt_mask;
				end
				fcs_pkg::ADDR_CHECKER_ENABLE: begin
					s_d.rdata[fcs_pkg::BIT_ENABLE] = s_q.checker_enable;
				end
				fcs_pkg::ADDR_IRQ_ENABLE: begin
					s_d.rdata[fcs_pkg::BIT_ENABLE] = s_q.irq_enable;
				end
				fcs_pkg::ADDR_SOURCE_SELECT: begin
					s_d.rdata[fcs_pkg::BIT_ENABLE] = s_q.source_select;
				end
				fcs_pkg::ADDR_MAX_FRAME_LIMIT: begin
					s_d.rdata = s_q.max_frame_length_limit;
				end
				fcs_pkg::ADDR_LOOPBACK_STATE: begin
					s_d.rdata[fcs_pkg::BIT_ENABLE] = s_q.source_select && remote_loopback_enable;
				end
				fcs_pkg::ADDR_TALLY: begin
					s_d.rdata = s_q.tally;
				end
				fcs_pkg::ADDR_FRAME_UPPER: begin
					s_d.rdata = s_q.frame_count_snapshot[31:16];
				end
				fcs_pkg::ADDR_FRAME_LOWER: begin
					s_d.rdata = s_q.frame_count_snapshot[15:0];
				end
				fcs_pkg::ADDR_LENGTH_SNAP: begin
					s_d.rdata = s_q.length_error_snapshot;
				end
				fcs_pkg::ADDR_ALIGN_SNAP: begin
					s_d.rdata = s_q.alignment_error_snapshot;
				end
				fcs_pkg::ADDR_SYMBOL_SNAP: begin
					s_d.rdata = s_q.symbol_error_snapshot;
				end
				fcs_pkg::ADDR_OVERSIZE_SNAP: begin
					s_d.rdata = s_q.oversize_frame_snapshot;
				end
				default: begin
					s_d.rdata = fcs_pkg::RST_ZERO16;
				end
			endcase
		end
	end

	// State register; reset gives the documented defaults
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.checker_enable <= fcs_pkg::RST_CHECKER_ENABLE;
			s_q.irq_enable <= fcs_pkg::RST_IRQ_ENABLE;
			s_q.source_select <= fcs_pkg::RST_SOURCE_SELECT;
			s_q.max_frame_length_limit <= fcs_pkg::RST_MAX_FRAME_LIMIT;
			s_q.subsystem_interrupt_mask <= fcs_pkg::RST_SUBSYS_MASK;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs; the interrupt needs the mask bit that software owns
	assign reg_rdata = s_q.rdata;
	assign irq = s_q.checker_generator_status_bit &&
		s_q.subsystem_interrupt_mask[fcs_pkg::BIT_CHKGEN];
	assign loopback_check_active = s_q.source_select && remote_loopback_enable;

	// Named access and event sequences used by the checks below
	sequence s_tally_rd;
		reg_rd && (reg_addr == fcs_pkg::ADDR_TALLY);
	endsequence
	// An error frame that ends while the checker interrupt is switched off
	sequence s_irq_off;
		!s_q.irq_enable && frame_evt && err_frame;
	endsequence

	property p_tally_clear;
		@(posedge core_clk) disable iff (!rst_b)
		s_tally_rd and !frame_evt |=> s_q.tally == 16'h0000;
	endproperty
	a_tally_clear: assert property (p_tally_clear) else $error("tally not cleared by read");

	property p_tally_rdata;
		@(posedge core_clk) disable iff (!rst_b)
		s_tally_rd |=> reg_rdata == $past(s_q.tally);
	endproperty
	a_tally_rdata: assert property (p_tally_rdata) else $error("tally read data wrong");

	property p_err_counts;
		@(posedge core_clk) disable iff (!rst_b)
		frame_evt && err_frame && !rd_tally |=> s_q.tally == $past(s_q.tally) + 16'h0001;
	endproperty
	a_err_counts: assert property (p_err_counts) else $error("error frame not tallied");

	property p_snap_frame;
		@(posedge core_clk) disable iff (!rst_b)
		s_tally_rd |=> s_q.frame_count_snapshot == $past(s_q.frame_count);
	endproperty
	a_snap_frame: assert property (p_snap_frame) else $error("frame snapshot wrong");

	property p_snap_hold;
		@(posedge core_clk) disable iff (!rst_b)
		!rd_tally |=> $stable(s_q.frame_count_snapshot) && $stable(s_q.oversize_frame_snapshot);
	endproperty
	a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved without read");

	property p_live_keeps;
		@(posedge core_clk) disable iff (!rst_b)
		rd_tally && frame_evt |=> s_q.frame_count == $past(s_q.frame_count) + 32'h0000_0001;
	endproperty
	a_live_keeps: assert property (p_live_keeps) else $error("live counter lost on read");

	property p_disabled;
		@(posedge core_clk) disable iff (!rst_b)
		!s_q.checker_enable |=> $stable(s_q.frame_count) && $stable(s_q.symbol_errors);
	endproperty
	a_disabled: assert property (p_disabled) else $error("counted while disabled");

	property p_status_set;
		@(posedge core_clk) disable iff (!rst_b)
		chk_event |=> s_q.checker_generator_status_bit &&
			(irq == s_q.subsystem_interrupt_mask[fcs_pkg::BIT_CHKGEN]);
	endproperty
	a_status_set: assert property (p_status_set) else $error("status bit not latched");

	property p_irq_off;
		@(posedge core_clk) disable iff (!rst_b)
		s_irq_off ##0 (!s_q.checker_generator_status_bit && !rd_status)
			|=> !s_q.checker_generator_status_bit;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("event raised while disabled");

	property p_oversize;
		@(posedge core_clk) disable iff (!rst_b)
		frame_evt && (sel_len > s_q.max_frame_length_limit)
			|=> s_q.oversize_frames == $past(s_q.oversize_frames) + 16'h0001;
	endproperty
	a_oversize: assert property (p_oversize) else $error("oversize frame not counted");

	property p_source;
		@(posedge core_clk) disable iff (!rst_b)
		s_q.source_select && mac_frame_end && s_q.checker_enable
			|=> s_q.frame_count == $past(s_q.frame_count) + 32'h0000_0001;
	endproperty
	a_source: assert property (p_source) else $error("MAC side frame not checked");

	// A status read with no event in the same cycle empties the bit
	property p_status_clear;
		@(posedge core_clk) disable iff (!rst_b)
		rd_status && !chk_event |=> !s_q.checker_generator_status_bit;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status not cleared");

	// Without a read the bit stays latched, whatever the mask says
	property p_status_hold;
		@(posedge core_clk) disable iff (!rst_b)
		s_q.checker_generator_status_bit && !rd_status
			|=> s_q.checker_generator_status_bit;
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status bit dropped");

	// A symbol error on the closing beat still counts for that frame
	property p_symbol;
		@(posedge core_clk) disable iff (!rst_b)
		frame_evt && sel_dv && sel_er
			|=> s_q.symbol_errors == $past(s_q.symbol_errors) + 16'h0001;
	endproperty
	a_symbol: assert property (p_symbol) else $error("symbol error not counted");

	// Length error flag at frame end bumps its live counter
	property p_length;
		@(posedge core_clk) disable iff (!rst_b)
		frame_evt && sel_len_err
			|=> s_q.length_errors == $past(s_q.length_errors) + 16'h0001;
	endproperty
	a_length: assert property (p_length) else $error("length error not counted");

	// Alignment error flag at frame end bumps its live counter
	property p_align;
		@(posedge core_clk) disable iff (!rst_b)
		frame_evt && sel_align
			|=> s_q.align_errors == $past(s_q.align_errors) + 16'h0001;
	endproperty
	a_align: assert property (p_align) else $error("alignment error not counted");

endmodule // fcs_checker
`default_nettype wire

// >>> rtl/fcs_pkg.sv
// Shared constants for the frame checker statistics block
package fcs_pkg;
	// Register word width and address width of the plain register port
	localparam int DW = 16;
	localparam int AW = 16;
	// Register offsets (word indexes on the register port)
	localparam logic [15:0] ADDR_SUBSYS_STATUS = 16'h0011;
	localparam logic [15:0] ADDR_SUBSYS_MASK = 16'h0021;
	localparam logic [15:0] ADDR_CHECKER_ENABLE = 16'h8001;
	localparam logic [15:0] ADDR_IRQ_ENABLE = 16'h8004;
	localparam logic [15:0] ADDR_SOURCE_SELECT = 16'h8005;
	localparam logic [15:0] ADDR_MAX_FRAME_LIMIT = 16'h8007;
	localparam logic [15:0] ADDR_LOOPBACK_STATE = 16'h8012;
	localparam logic [15:0] ADDR_TALLY = 16'h8008;
	localparam logic [15:0] ADDR_FRAME_UPPER = 16'h8009;
	localparam logic [15:0] ADDR_FRAME_LOWER = 16'h800A;
	localparam logic [15:0] ADDR_LENGTH_SNAP = 16'h800B;
	localparam logic [15:0] ADDR_ALIGN_SNAP = 16'h800C;
	localparam logic [15:0] ADDR_SYMBOL_SNAP = 16'h800D;
	localparam logic [15:0] ADDR_OVERSIZE_SNAP = 16'h800E;
	// Reset values
	localparam logic RST_CHECKER_ENABLE = 1'b1;
	localparam logic RST_IRQ_ENABLE = 1'b1;
	localparam logic RST_SOURCE_SELECT = 1'b0;
	localparam logic [15:0] RST_SUBSYS_MASK = 16'h2402;
	localparam logic [15:0] RST_MAX_FRAME_LIMIT = 16'h05EE;
	localparam logic [15:0] RST_ZERO16 = 16'h0000;
	localparam logic [31:0] RST_ZERO32 = 32'h0000_0000;
	// Field positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_CHKGEN = 14;
	// Increment step for every counter
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [31:0] ONE32 = 32'h0000_0001;

	// Complete state of the block, registered as one word
	typedef struct packed {
		logic checker_enable;
		logic irq_enable;
		logic source_select;
		logic [15:0] max_frame_length_limit;
		logic [15:0] subsystem_interrupt_mask;
		logic checker_generator_status_bit;
		logic symbol_seen;
		logic [15:0] tally;
		logic [31:0] frame_count;
		logic [15:0] length_errors;
		logic [15:0] align_errors;
		logic [15:0] symbol_errors;
		logic [15:0] oversize_frames;
		logic [31:0] frame_count_snapshot;
		logic [15:0] length_error_snapshot;
		logic [15:0] alignment_error_snapshot;
		logic [15:0] symbol_error_snapshot;
		logic [15:0] oversize_frame_snapshot;
		logic [15:0] rdata;
	} fcs_state_t;
endpackage

// >>> testbench/fcs_stream_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far-side frame source, either the PHY receive path or the MAC-side stream
module fcs_stream_model (
	output logic rx_dv, // Data valid
	output logic rx_er, // Symbol error
	output logic frame_end, // End-of-frame pulse
	output logic [15:0] frame_len, // Frame length in bytes
	output logic crc_err, // Bad check sequence
	output logic len_err, // Length field mismatch
	output logic align_err, // Alignment error
	input wire logic core_clk // Device clock
);
	// Idle stream at time zero
	initial begin
		rx_dv = 1'b0;
		rx_er = 1'b0;
		frame_end = 1'b0;
		frame_len = 16'h0000;
		{crc_err, len_err, align_err} = 3'h0;
	end
	// One frame of three data cycles; flags are symbol, align, length, crc
	task automatic send(input logic [15:0] len, input logic [3:0] flags);
		@(posedge core_clk);
		rx_dv <= 1'b1;
		rx_er <= flags[3];
		repeat (2) @(posedge core_clk);
		frame_end <= 1'b1;
		frame_len <= len;
		{align_err, len_err, crc_err} <= flags[2:0];
		@(posedge core_clk);
		// Released status lines carry junk so a late sample cannot match by luck
		frame_end <= 1'b0;
		rx_dv <= 1'b0;
		frame_len <= ~len;
		{align_err, len_err, crc_err} <= ~flags[2:0];
	endtask
endmodule // fcs_stream_model
`default_nettype wire

// >>> testbench/test_frame_checker_statistics.sv
`timescale 1ns/10ps
`default_nettype none
module test_frame_checker_statistics;
	logic core_clk = 1'b0; // 100 MHz clock
	logic rst_b = 1'b0; // Reset, active low
	logic [15:0] reg_addr = 16'h0000; // Register index
	logic [15:0] reg_wdata = 16'h0000; // Write data
	logic reg_wr = 1'b0; // Write strobe
	logic reg_rd = 1'b0; // Read strobe
	logic remote_loopback_enable = 1'b0; // Loopback control level
	logic [15:0] reg_rdata; // Read data
	logic loopback_check_active; // Looped data under check
	logic irq; // Level interrupt
	logic p_dv, p_er, p_end, p_crc, p_len, p_al; // PHY stream
	logic m_dv, m_er, m_end, m_crc, m_len, m_al; // MAC stream
	logic [15:0] p_flen, m_flen; // Frame lengths
	int num_errors = 0; // Mismatches
	int n_compared = 0; // Comparisons
	// Reset values: address beside expected read data; last row is unmapped
	logic [15:0] rows [15][2] = '{'{16'h8001, 16'h0001}, '{16'h8004, 16'h0001},
		'{16'h8005, 16'h0000}, '{16'h8007, 16'h05EE}, '{16'h0021, 16'h2402},
		'{16'h0011, 16'h0000}, '{16'h8008, 16'h0000}, '{16'h8009, 16'h0000},
		'{16'h800A, 16'h0000}, '{16'h800B, 16'h0000}, '{16'h800C, 16'h0000},
		'{16'h800D, 16'h0000}, '{16'h800E, 16'h0000}, '{16'h8012, 16'h0000},
		'{16'h1234, 16'h0000}};
	always #5 core_clk = ~core_clk;
	fcs_stream_model phy_m (.rx_dv(p_dv), .rx_er(p_er), .frame_end(p_end), .frame_len(p_flen),
		.crc_err(p_crc), .len_err(p_len), .align_err(p_al), .core_clk(core_clk));
	fcs_stream_model mac_m (.rx_dv(m_dv), .rx_er(m_er), .frame_end(m_end), .frame_len(m_flen),
		.crc_err(m_crc), .len_err(m_len), .align_err(m_al), .core_clk(core_clk));
	fcs_checker dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.phy_rx_dv(p_dv), .phy_rx_er(p_er), .phy_frame_end(p_end), .phy_frame_len(p_flen),
		.phy_crc_err(p_crc), .phy_len_err(p_len), .phy_align_err(p_al),
		.mac_rx_dv(m_dv), .mac_rx_er(m_er), .mac_frame_end(m_end), .mac_frame_len(m_flen),
		.mac_crc_err(m_crc), .mac_len_err(m_len), .mac_align_err(m_al),
		.remote_loopback_enable(remote_loopback_enable),
		.loopback_check_active(loopback_check_active), .irq(irq));
	// Compare and count
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data is only valid in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check($sformatf("reg %h", a), reg_rdata, exp);
	endtask
	// Tally read, then every snapshot it latched
	task automatic snap(input logic [15:0] t, lo, le, al, sy, os);
		rd(16'h8008, t);
		rd(16'h8009, 16'h0000);
		rd(16'h800A, lo);
		rd(16'h800B, le);
		rd(16'h800C, al);
		rd(16'h800D, sy);
		rd(16'h800E, os);
	endtask
	task automatic conclude();
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#50000;
		num_errors++;
		conclude();
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		foreach (rows[i]) rd(rows[i][0], rows[i][1]);
		// Symbol error frame with the checker/generator mask bit set
		wr(16'h0021, 16'h6402);
		phy_m.send(16'h0040, 4'h8);
		#1 check("irq", {15'h0, irq}, 16'h0001);
		rd(16'h0011, 16'h4000);
		check("irq", {15'h0, irq}, 16'h0000);
		rd(16'h0011, 16'h0000);
		// Length, alignment and oversize errors, boundary lengths, and a frame on the unselected stream
		phy_m.send(16'h0040, 4'h2);
		phy_m.send(16'h0040, 4'h4);
		phy_m.send(16'h05EF, 4'h0);
		phy_m.send(16'h05EE, 4'h0);
		mac_m.send(16'h0040, 4'h1);
		snap(16'h0004, 16'h0005, 16'h0001, 16'h0001, 16'h0001, 16'h0001);
		rd(16'h8008, 16'h0000);
		// Snapshots hold while live counters advance
		phy_m.send(16'h0040, 4'h2);
		rd(16'h800B, 16'h0001);
		snap(16'h0001, 16'h0006, 16'h0002, 16'h0001, 16'h0001, 16'h0001);
		// Empty the status bit so the looped frame must set it again
		rd(16'h0011, 16'h4000);
		// MAC side with remote loopback
		wr(16'h8005, 16'h0001);
		remote_loopback_enable <= 1'b1;
		rd(16'h8012, 16'h0001);
		check("loopback", {15'h0, loopback_check_active}, 16'h0001);
		mac_m.send(16'h0040, 4'h1);
		phy_m.send(16'h0040, 4'h1);
		rd(16'h0011, 16'h4000);
		snap(16'h0001, 16'h0007, 16'h0002, 16'h0001, 16'h0001, 16'h0001);
		// Checker disabled: nothing counts
		wr(16'h8001, 16'h0000);
		mac_m.send(16'h0040, 4'h1);
		wr(16'h8001, 16'h0001);
		snap(16'h0000, 16'h0007, 16'h0002, 16'h0001, 16'h0001, 16'h0001);
		// Interrupt enable off: error tallied, no event
		wr(16'h8004, 16'h0000);
		mac_m.send(16'h0040, 4'h1);
		#1 check("irq", {15'h0, irq}, 16'h0000);
		rd(16'h0011, 16'h0000);
		snap(16'h0001, 16'h0008, 16'h0002, 16'h0001, 16'h0001, 16'h0001);
		// Reset in mid-run restores every register
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		foreach (rows[i]) rd(rows[i][0], rows[i][1]);
		// Loopback level is still high, but the source select went back to the PHY side
		check("loopback", {15'h0, loopback_check_active}, 16'h0000);
		conclude();
	end
endmodule // test_frame_checker_statistics
`default_nettype wire
